// File: hw/grra_pkg.sv
// Notes on behaviour
// RULE1: at 1 Gb/s each reference cycle carries a new byte, passed straight through.
// RULE2: at 100 Mb/s bytes hold 10 cycles, at 10 Mb/s 100; one item each.
// RULE3: core data is captured only on cycles where the rate enable is high.
// RULE4: MAC mode detects a delimiter split over two bytes and realigns nibbles.
// RULE5: client MAC samples receive data on the reference clock, qualified by rate enable.
// RULE6: PHY mode reduced speed sends low nibble then high nibble on data bits 3:0.
// RULE7: PHY mode nibble steps advance on the nibble enable, not the rate enable.
// RULE8: rate enable runs at 125, 12.5 or 1.25 MHz for the three speeds.
// RULE9: forwarded clock phases run at 125 MHz, or 25/2.5 MHz in reduced-speed PHY mode.
// RULE10: a per-channel forwarded clock is derived from the rise and fall phases.
// RULE11: rise and fall phases feed a double-data-rate output register off chip.
// RULE12: PHY mode sends received data out toward the external PHY.
// RULE13: PHY mode MII transmit takes 4-bit data and assembles bytes on nibble enable; at 1 Gb/s the code passes 8-bit data through each cycle.
// RULE14: rate enable is a one-cycle pulse every 1, 10 or 100 cycles; count restarts on reset.
// RULE15: at reduced speed nibble enable pulses twice per rate period, evenly spaced; at 1 Gb/s it stays high.
package grra_pkg;
  localparam logic [1:0] SPEED_1G = 2'h2;
  localparam logic [1:0] SPEED_100M = 2'h1;
  localparam logic [1:0] SPEED_10M = 2'h0;
  localparam int REF_CLOCK_HZ = 125000000;
  localparam int DIV_100M = 10;
  localparam int DIV_10M = 100;
  localparam logic [7:0] SFD_BYTE = 8'hd5;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [3:0] SFD_HIGH_NIBBLE = 4'hd;
  localparam logic [3:0] PREAMBLE_NIBBLE = 4'h5;
  localparam logic [6:0] COUNT_RESET = 7'h00;
  typedef enum logic [1:0] {
    GRRA_IDLE = 2'b00,
    GRRA_ALIGNED = 2'b01,
    GRRA_SHIFTED = 2'b10
  } grra_align_t;
endpackage

// File: hw/grra_rx_rate_adapt.sv
`timescale 1ns/1ps
module grra_rx_rate_adapt
  import grra_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] speed,
  input wire logic phyMode,
  input wire logic [7:0] coreRxd,
  input wire logic coreRxDv,
  input wire logic coreRxEr,
  input wire logic [7:0] miiTxd,
  input wire logic miiTxEn,
  input wire logic miiTxEr,
  output logic [7:0] gmiiRxdOut,
  output logic gmiiRxDvOut,
  output logic gmiiRxErOut,
  output logic rateClkEn,
  output logic nibbleClkEn,
  output logic fwdClkRise,
  output logic fwdClkFall,
  output logic [7:0] coreTxd,
  output logic coreTxEn,
  output logic coreTxEr
);
  typedef struct packed {
    logic [6:0] cnt;
    logic rateEn;
    logic nibEn;
    logic rise;
    logic fall;
    grra_align_t align;
    logic [3:0] lastHigh;
    logic [7:0] rxd;
    logic dv;
    logic er;
    logic [7:0] held;
    logic heldDv;
    logic heldEr;
    logic nibHigh;
    logic [3:0] txLow;
    logic txHalf;
    logic [7:0] txd;
    logic txEn;
    logic txEr;
  } grra_state_t;

  grra_state_t st;
  grra_state_t next_st;

  function automatic logic [6:0] divOf(input logic [1:0] spd);
    case (spd)
      SPEED_1G: divOf = 7'd1;
      SPEED_100M: divOf = 7'(DIV_100M);
      default: divOf = 7'(DIV_10M);
    endcase
  endfunction

  // wraps the period count onto one forwarded clock period
  function automatic logic [6:0] wrapIdx(input logic [6:0] count, input logic [6:0] half);
    if (count >= half) begin
      wrapIdx = count - half;
    end else begin
      wrapIdx = count;
    end
  endfunction

  // level of one half cycle of the forwarded clock, high in the first half period
  function automatic logic fwdLevel(input logic [6:0] idx, input logic late,
      input logic [6:0] half);
    logic [7:0] halfStep;
    halfStep = {idx, late};
    fwdLevel = (halfStep < {1'b0, half});
  endfunction

  // one nibble of a byte on the low data bits
  function automatic logic [7:0] nibbleOut(input logic [7:0] data, input logic upper);
    if (upper) begin
      nibbleOut = {4'h0, data[7:4]};
    end else begin
      nibbleOut = {4'h0, data[3:0]};
    end
  endfunction

  // delimiter high nibble arriving in the low half of a byte
  function automatic logic skewedSfd(input logic [7:0] data, input logic prevDv);
    skewedSfd = prevDv && data[3:0] == SFD_HIGH_NIBBLE && data[7:4] != PREAMBLE_NIBBLE;
  endfunction

  logic [6:0] div;
  logic [6:0] halfDiv;
  logic [6:0] phIdx;
  logic reduced;
  logic endPeriod;

  always_comb begin
    div = divOf(speed);
    halfDiv = div >> 1;
    phIdx = wrapIdx(st.cnt, halfDiv);
    reduced = (speed != SPEED_1G);
    endPeriod = (st.cnt >= div - 7'd1);
    next_st = st;
    // rate enable divider, one pulse per period
    next_st.cnt = endPeriod ? COUNT_RESET : st.cnt + 7'd1; // RULE14
    next_st.rateEn = endPeriod; // RULE8 RULE14
    // nibble enable: at start and middle of each period
    next_st.nibEn = !reduced || endPeriod || (st.cnt == halfDiv - 7'd1); // RULE15
    // forwarded clock phases: full rate, or one clock period per half rate period
    if (!reduced || !phyMode) begin
      next_st.rise = 1'b1; // RULE9
      next_st.fall = 1'b0;
    end else begin
      next_st.rise = fwdLevel(phIdx, 1'b0, halfDiv); // RULE9 RULE10 RULE11
      next_st.fall = fwdLevel(phIdx, 1'b1, halfDiv); // RULE9 RULE10 RULE11
    end
    // receive capture on rate enable
    if (st.rateEn) begin // RULE3 RULE2 RULE1
      next_st.dv = coreRxDv;
      next_st.er = coreRxEr;
      next_st.rxd = coreRxd;
      next_st.held = coreRxd;
      next_st.heldDv = coreRxDv;
      next_st.heldEr = coreRxEr;
      next_st.nibHigh = 1'b0;
      if (!phyMode) begin
        // delimiter realignment for nibble-skewed frames
        next_st.lastHigh = coreRxd[7:4];
        case (st.align)
          GRRA_IDLE: begin
            if (coreRxDv && coreRxd == SFD_BYTE) begin
              next_st.align = GRRA_ALIGNED;
            end else if (coreRxDv && skewedSfd(coreRxd, st.dv)) begin
              // split delimiter: join its low half kept from the byte before
              next_st.align = GRRA_SHIFTED; // RULE4
              next_st.rxd = {coreRxd[3:0], st.lastHigh}; // RULE4
            end
          end
          GRRA_SHIFTED: begin
            next_st.rxd = {coreRxd[3:0], st.lastHigh}; // RULE4
            if (!coreRxDv) begin
              next_st.align = GRRA_IDLE;
            end
          end
          GRRA_ALIGNED: begin
            if (!coreRxDv) begin
              next_st.align = GRRA_IDLE;
            end
          end
          default: next_st.align = GRRA_IDLE;
        endcase
      end else begin
        next_st.align = GRRA_IDLE;
        if (reduced) begin
          next_st.rxd = nibbleOut(coreRxd, 1'b0); // RULE6 RULE12
        end
      end
    end else if (phyMode && reduced && st.nibEn && !st.nibHigh) begin
      next_st.rxd = nibbleOut(st.held, 1'b1); // RULE6 RULE7
      next_st.nibHigh = 1'b1;
    end
    // MII transmit byte assembly
    if (phyMode && reduced) begin
      if (st.nibEn) begin // RULE13
        if (!st.txHalf) begin
          next_st.txLow = miiTxd[3:0];
          next_st.txHalf = miiTxEn;
        end else begin
          next_st.txd = {miiTxd[3:0], st.txLow};
          next_st.txEn = miiTxEn;
          next_st.txEr = miiTxEr;
          next_st.txHalf = 1'b0;
        end
      end
    end else begin
      next_st.txd = miiTxd;
      next_st.txEn = miiTxEn;
      next_st.txEr = miiTxEr;
      next_st.txHalf = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign gmiiRxdOut = st.rxd;
  assign gmiiRxDvOut = st.dv;
  assign gmiiRxErOut = st.er;
  assign rateClkEn = st.rateEn; // RULE5
  assign nibbleClkEn = st.nibEn;
  assign fwdClkRise = st.rise;
  assign fwdClkFall = st.fall;
  assign coreTxd = st.txd;
  assign coreTxEn = st.txEn;
  assign coreTxEr = st.txEr;
endmodule

// File: test/grra_mac_model.sv
`timescale 1ns/1ps
module grra_mac_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic rateClkEn,
  input wire logic gmiiRxDvOut,
  input wire logic [7:0] gmiiRxdOut,
  output logic [7:0] lastByte,
  output logic [7:0] byteCount
);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      byteCount <= 8'h00;
    end else if (rateClkEn && gmiiRxDvOut) begin
      lastByte <= gmiiRxdOut;
      byteCount <= byteCount + 8'h01;
    end
  end
endmodule

// File: test/grra_props.sv
`timescale 1ns/1ps
module grra_props
  import grra_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] speed,
  input wire logic phyMode,
  input wire logic [7:0] coreRxd,
  input wire logic [7:0] gmiiRxdOut,
  input wire logic rateClkEn,
  input wire logic nibbleClkEn,
  input wire logic fwdClkRise,
  input wire logic fwdClkFall
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire mid = speed == SPEED_100M;
  wire pFast = phyMode && speed == SPEED_1G;
  wire pSlow = phyMode && speed != SPEED_1G;
  a_gig_rx: assert property (pFast && rateClkEn |=> gmiiRxdOut == $past(coreRxd))
    else $error("gig data");
  a_mid_rate: assert property (mid && rateClkEn |=>
    !rateClkEn [*8] ##1 !rateClkEn ##1 rateClkEn) else $error("rate period");
  a_mid_nib: assert property (mid && nibbleClkEn |-> ##5 nibbleClkEn)
    else $error("nibble spacing");
  a_low_nib: assert property (pSlow && rateClkEn |=>
    gmiiRxdOut == {4'h0, $past(coreRxd[3:0])}) else $error("low nibble");
  a_phy_hold: assert property (pSlow && !rateClkEn && !nibbleClkEn |=>
    $stable(gmiiRxdOut)) else $error("phy hold");
  a_mac_hold: assert property (!phyMode && !rateClkEn |=> $stable(gmiiRxdOut))
    else $error("mac hold");
  a_fwd_full: assert property (!pSlow |=> fwdClkRise)
    else $error("fwd full");
  a_fwd_mid: assert property (phyMode && mid && $rose(fwdClkRise) |->
    ##5 $rose(fwdClkRise)) else $error("fwd period");
  a_fwd_fall: assert property (!pSlow |=> !fwdClkFall)
    else $error("fwd fall");
  c_gig: cover property (pFast && rateClkEn);
  c_fwd: cover property (pSlow && $rose(fwdClkRise));
  c_nib: cover property (pSlow && nibbleClkEn);
  c_mac: cover property (!phyMode && mid && rateClkEn);
endmodule
bind grra_rx_rate_adapt grra_props u_props (.*);

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import grra_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, phyMode = 1'b0, coreRxDv = 1'b0, miiTxEn = 1'b0;
  logic coreRxEr = 1'b0, miiTxEr = 1'b0;
  logic [1:0] speed = SPEED_1G;
  logic [7:0] coreRxd = 8'h00, miiTxd = 8'h00, gmiiRxdOut, coreTxd, macByte, macCount;
  logic gmiiRxDvOut, gmiiRxErOut, rateClkEn, nibbleClkEn, fwdClkRise, fwdClkFall;
  logic coreTxEn, coreTxEr;
  int n_fail = 0, checks_done = 0;
  always #50 core_clk = ~core_clk;
  grra_rx_rate_adapt u_dut (.core_clk, .sys_rst, .speed, .phyMode, .coreRxd, .coreRxDv,
    .coreRxEr, .miiTxd, .miiTxEn, .miiTxEr, .gmiiRxdOut, .gmiiRxDvOut,
    .gmiiRxErOut, .rateClkEn, .nibbleClkEn, .fwdClkRise, .fwdClkFall, .coreTxd,
    .coreTxEn, .coreTxEr);
  grra_mac_model u_mac (.core_clk, .sys_rst, .rateClkEn, .gmiiRxDvOut, .gmiiRxdOut,
    .lastByte(macByte), .byteCount(macCount));
  task automatic chk(input logic [7:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic waitEn(input bit nib);
    int i;
    for (i = 0; i < 200 && (nib ? nibbleClkEn : rateClkEn) !== 1'b1; i++) cyc(1);
    if (i == 200) begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic restart(input logic [1:0] s, input logic p);
    sys_rst = 1'b1;
    speed = s;
    phyMode = p;
    cyc(2);
    sys_rst = 1'b0;
  endtask
  task automatic s_gig;
    restart(SPEED_1G, 1'b1);
    waitEn(0);
    for (int i = 1; i < 9; i++) begin
      coreRxd = 8'(i * 37);
      coreRxEr = i[0];
      cyc(1);
      chk(gmiiRxdOut, 8'(i * 37), "gig");
      chk({7'h00, gmiiRxErOut}, {7'h00, i[0]}, "gig er");
    end
    coreRxEr = 1'b0;
  endtask
  task automatic s_rate(input logic [1:0] s, input logic [7:0] div);
    logic [7:0] n, k;
    restart(s, 1'b1);
    waitEn(0);
    n = 8'h00;
    k = 8'h00;
    do begin
      cyc(1);
      n++;
      k += nibbleClkEn;
    end while (rateClkEn !== 1'b1 && n < 8'hc8);
    chk(n, div, "period");
    chk(k, 8'h02, "nibbles");
  endtask
  task automatic s_nib;
    logic [7:0] r, f;
    restart(SPEED_100M, 1'b1);
    coreRxd = 8'h7c;
    waitEn(0);
    cyc(1);
    chk(gmiiRxdOut, 8'h0c, "low");
    cyc(6);
    chk(gmiiRxdOut, 8'h07, "high");
    r = 8'h00;
    f = 8'h00;
    repeat (10) begin
      cyc(1);
      r += 8'(fwdClkRise);
      f += 8'(fwdClkFall);
    end
    chk(r, 8'h06, "rise phase");
    chk(f, 8'h04, "fall phase");
  endtask
  task automatic s_mac;
    logic [7:0] fr [4] = '{PREAMBLE_BYTE, PREAMBLE_BYTE, SFD_BYTE, 8'h3c};
    restart(SPEED_100M, 1'b0);
    for (int i = 0; i < 4; i++) begin
      waitEn(0);
      coreRxd = fr[i];
      coreRxDv = 1'b1;
      cyc(1);
    end
    waitEn(0);
    coreRxDv = 1'b0;
    cyc(40);
    chk(macCount, 8'h04, "count");
    chk(macByte, 8'h3c, "last");
    chk({6'h00, fwdClkRise, fwdClkFall}, 8'h02, "fwd");
  endtask
  task automatic s_mii;
    restart(SPEED_100M, 1'b1);
    miiTxd = 8'h03;
    miiTxEn = 1'b1;
    miiTxEr = 1'b1;
    for (int j = 0; j < 8; j++) begin
      waitEn(1);
      cyc(1);
      miiTxd = j[0] ? 8'h03 : 8'h0a;
    end
    cyc(2);
    chk(coreTxd, 8'ha3, "tx");
    chk({6'h00, coreTxEn, coreTxEr}, 8'h03, "tx flags");
    miiTxEn = 1'b0;
    miiTxEr = 1'b0;
  endtask
  task automatic s_skew;
    logic [7:0] fr [4] = '{PREAMBLE_BYTE, PREAMBLE_BYTE, 8'h3d, 8'h7c};
    logic [7:0] ex [4] = '{PREAMBLE_BYTE, PREAMBLE_BYTE, SFD_BYTE, 8'hc3};
    restart(SPEED_1G, 1'b0);
    waitEn(0);
    coreRxDv = 1'b1;
    for (int i = 0; i < 4; i++) begin
      coreRxd = fr[i];
      cyc(1);
      chk(gmiiRxdOut, ex[i], "skew");
    end
    coreRxDv = 1'b0;
    cyc(3);
    chk(macCount, 8'h04, "skew count");
  endtask
  initial begin
    cyc(12);
    s_gig();
    s_rate(SPEED_100M, 8'h0a);
    s_rate(SPEED_10M, 8'h64);
    s_nib();
    s_mac();
    s_skew();
    s_mii();
    test_done();
  end
endmodule
